// ===== inc/sws_pkg.sv
package sws_pkg;

    // ------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int STAB_TICK_NS = 4000;
    localparam int STAB_TICK_CYCLES = (STAB_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 7;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STAB_TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // Widths and thresholds.
    // ------------------------------------------------------------
    localparam int NUM_IRQ = 8;
    localparam int SEL_W = 3;
    localparam int STAT_W = 8;
    localparam int CNT_W = 11;
    localparam int THR_BASE_SHIFT = 3;

    // ------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam logic [ADDR_W-1:0] OFS_WAIT_SEL = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] OFS_OPTION = 32'h0000_0008;
    localparam logic [ADDR_W-1:0] OFS_STATE = 32'h0000_000C;
    localparam int OPT_WDT_BIT = 0;
    localparam int STATE_DEEP_BIT = 0;
    localparam int STATE_LIGHT_BIT = 1;
    localparam int STATE_OSC_OK_BIT = 2;
    localparam logic [SEL_W-1:0] WAIT_SEL_RST = 3'h7;
    localparam logic OPTION_RST = 1'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_DEEP, ST_LIGHT, ST_STAB} sws_mode_t;

    typedef struct packed {
        logic [SEL_W-1:0] osc_stab_wait_select;
        logic wdt_runs_in_standby_option;
    } sws_cfg_t;

endpackage

// ===== verilog/sws_standby_wake_osc_stabilizer.sv
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns

module sws_standby_wake_osc_stabilizer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_exec,
    input wire logic [sws_pkg::NUM_IRQ-1:0] int_request,
    input wire logic [sws_pkg::NUM_IRQ-1:0] int_mask,
    input wire logic crystal_oscillator_started,
    output logic cpu_run,
    output logic deep_standby,
    output logic light_standby,
    output logic crystal_oscillator_enable,
    output logic low_speed_osc_stop
);

    // ------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------
    function automatic logic [sws_pkg::CNT_W-1:0] thr(input logic [sws_pkg::SEL_W-1:0] sel);
        thr = sws_pkg::CNT_W'(1) << (sws_pkg::CNT_W'(sel) + sws_pkg::CNT_W'(sws_pkg::THR_BASE_SHIFT));
    endfunction

    function automatic logic [sws_pkg::STAT_W-1:0] sel_mask(input logic [sws_pkg::SEL_W-1:0] sel);
        logic [sws_pkg::STAT_W-1:0] m;
        m = '0;
        for (int i = 0; i < sws_pkg::STAT_W; i++)
        begin
            if (i <= int'(sel))
            begin
                m[sws_pkg::STAT_W-1-i] = 1'b1;
            end
        end
        sel_mask = m;
    endfunction

    function automatic logic [sws_pkg::STAT_W-1:0] stat_of(input logic [sws_pkg::CNT_W-1:0] cnt,
                                                       input logic [sws_pkg::SEL_W-1:0] sel);
        logic [sws_pkg::STAT_W-1:0] s;
        s = '0;
        for (int i = 0; i < sws_pkg::STAT_W; i++)
        begin
            if (cnt >= thr(sws_pkg::SEL_W'(i)))
            begin
                s[sws_pkg::STAT_W-1-i] = 1'b1;
            end
        end
        stat_of = s & sel_mask(sel);
    endfunction

    // ------------------------------------------------------------
    // Oscillator start input synchroniser.
    // ------------------------------------------------------------
    logic osc_s1, osc_s2, osc_s3, osc_ok, next_osc_ok;

    always_comb
    begin
        next_osc_ok = osc_ok;
        if (osc_s2 == osc_s3)
        begin
            next_osc_ok = osc_s3;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            osc_ok <= 1'b0;
        end
        else
        begin
            osc_s1 <= crystal_oscillator_started;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            osc_ok <= next_osc_ok;
        end
    end

    // ------------------------------------------------------------
    // Standby sequencer and stabilization counter.
    // ------------------------------------------------------------
    sws_pkg::sws_mode_t mode, next_mode;
    sws_pkg::sws_cfg_t cfg, next_cfg;
    logic [sws_pkg::TICK_W-1:0] tick_div, next_tick_div;
    logic [sws_pkg::CNT_W-1:0] stab_cnt, next_stab_cnt;
    logic [sws_pkg::STAT_W-1:0] osc_stab_status_counter, next_status;
    logic pending, tick, waiting, elapsed;

    assign pending = |(int_request & ~int_mask);
    assign tick = (tick_div == sws_pkg::TICK_LAST);
    assign waiting = (mode == sws_pkg::ST_LIGHT) || (mode == sws_pkg::ST_STAB);
    assign elapsed = (stab_cnt >= thr(cfg.osc_stab_wait_select));

    always_comb
    begin
        next_mode = mode;
        next_stab_cnt = stab_cnt;
        next_status = osc_stab_status_counter;
        next_tick_div = tick ? '0 : tick_div + sws_pkg::TICK_W'(1);
        case (mode)
            sws_pkg::ST_RUN:
            begin
                if (stop_exec)
                begin
                    next_stab_cnt = '0;
                    next_status = '0;
                    next_mode = pending ? sws_pkg::ST_LIGHT : sws_pkg::ST_DEEP;
                end
            end
            sws_pkg::ST_DEEP:
            begin
                if (pending)
                begin
                    next_mode = sws_pkg::ST_STAB;
                end
            end
            sws_pkg::ST_LIGHT, sws_pkg::ST_STAB:
            begin
                if (elapsed)
                begin
                    next_mode = sws_pkg::ST_RUN;
                end
                else if (osc_ok && tick)
                begin
                    next_stab_cnt = stab_cnt + sws_pkg::CNT_W'(1);
                end
                next_status = osc_stab_status_counter | stat_of(stab_cnt, cfg.osc_stab_wait_select);
            end
            default:
            begin
                next_mode = sws_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode <= sws_pkg::ST_RUN;
            tick_div <= '0;
            stab_cnt <= '0;
            osc_stab_status_counter <= '0;
            cpu_run <= 1'b0;
            deep_standby <= 1'b0;
            light_standby <= 1'b0;
            crystal_oscillator_enable <= 1'b0;
            low_speed_osc_stop <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            tick_div <= next_tick_div;
            stab_cnt <= next_stab_cnt;
            osc_stab_status_counter <= next_status;
            cpu_run <= (next_mode == sws_pkg::ST_RUN);
            deep_standby <= (next_mode == sws_pkg::ST_DEEP);
            light_standby <= (next_mode == sws_pkg::ST_LIGHT) || (next_mode == sws_pkg::ST_STAB);
            crystal_oscillator_enable <= (next_mode != sws_pkg::ST_DEEP);
            low_speed_osc_stop <= (next_mode == sws_pkg::ST_DEEP) && !next_cfg.wdt_runs_in_standby_option;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite register slave.
    // ------------------------------------------------------------
    logic aw_have, w_have, next_aw_have, next_w_have;
    logic [31:0] aw_addr, w_data, next_aw_addr, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    always_comb
    begin
        next_cfg = cfg;
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (aw_have && w_have && !s_axi_bvalid)
        begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = sws_pkg::RESP_OKAY;
            case (aw_addr)
                sws_pkg::OFS_WAIT_SEL:
                begin
                    if (w_strb[0])
                    begin
                        next_cfg.osc_stab_wait_select = w_data[sws_pkg::SEL_W-1:0];
                    end
                end
                sws_pkg::OFS_OPTION:
                begin
                    if (w_strb[0])
                    begin
                        next_cfg.wdt_runs_in_standby_option = w_data[sws_pkg::OPT_WDT_BIT];
                    end
                end
                sws_pkg::OFS_STATUS, sws_pkg::OFS_STATE:
                begin
                    next_bresp = sws_pkg::RESP_OKAY;
                end
                default:
                begin
                    next_bresp = sws_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = sws_pkg::RESP_OKAY;
            next_rdata = '0;
            case (s_axi_araddr)
                sws_pkg::OFS_WAIT_SEL:
                begin
                    next_rdata[sws_pkg::SEL_W-1:0] = cfg.osc_stab_wait_select;
                end
                sws_pkg::OFS_STATUS:
                begin
                    next_rdata[sws_pkg::STAT_W-1:0] = osc_stab_status_counter;
                end
                sws_pkg::OFS_OPTION:
                begin
                    next_rdata[sws_pkg::OPT_WDT_BIT] = cfg.wdt_runs_in_standby_option;
                end
                sws_pkg::OFS_STATE:
                begin
                    next_rdata[sws_pkg::STATE_DEEP_BIT] = (mode == sws_pkg::ST_DEEP);
                    next_rdata[sws_pkg::STATE_LIGHT_BIT] = waiting;
                    next_rdata[sws_pkg::STATE_OSC_OK_BIT] = osc_ok;
                end
                default:
                begin
                    next_rresp = sws_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg <= '{sws_pkg::WAIT_SEL_RST, sws_pkg::OPTION_RST};
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sws_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= sws_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
        end
        else
        begin
            cfg <= next_cfg;
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= !next_aw_have;
            s_axi_wready <= !next_w_have;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    property p_status_capped;
        @(posedge aclk) disable iff (!aresetn)
        waiting |=> ((osc_stab_status_counter & ~sel_mask($past(cfg.osc_stab_wait_select))) == '0);
    endproperty
    a_status_capped: assert property (p_status_capped) else $error("status beyond selected wait");

    property p_no_count_before_osc;
        @(posedge aclk) disable iff (!aresetn)
        (waiting && !osc_ok) |=> (stab_cnt == $past(stab_cnt));
    endproperty
    a_no_count_before_osc: assert property (p_no_count_before_osc) else $error("counted before oscillation");

    property p_cancel_entry;
        @(posedge aclk) disable iff (!aresetn)
        (mode == sws_pkg::ST_RUN && stop_exec && pending) |=> (mode == sws_pkg::ST_LIGHT) && !deep_standby;
    endproperty
    a_cancel_entry: assert property (p_cancel_entry) else $error("standby not cancelled");

    property p_light_returns;
        @(posedge aclk) disable iff (!aresetn)
        (mode == sws_pkg::ST_LIGHT && stab_cnt >= thr(cfg.osc_stab_wait_select)) |=> cpu_run && !light_standby;
    endproperty
    a_light_returns: assert property (p_light_returns) else $error("no return after wait");

    property p_status_sticky_ordered;
        @(posedge aclk) disable iff (!aresetn)
        !(mode == sws_pkg::ST_RUN && stop_exec) |=> (((osc_stab_status_counter & $past(osc_stab_status_counter))
            == $past(osc_stab_status_counter)) && (((~osc_stab_status_counter) & ((~osc_stab_status_counter)
            + sws_pkg::STAT_W'(1))) == '0));
    endproperty
    a_status_sticky_ordered: assert property (p_status_sticky_ordered) else $error("status not sticky");

    property p_clear_on_entry;
        @(posedge aclk) disable iff (!aresetn)
        (mode == sws_pkg::ST_RUN && stop_exec && !pending) |=> deep_standby && stab_cnt == '0
            && osc_stab_status_counter == '0;
    endproperty
    a_clear_on_entry: assert property (p_clear_on_entry) else $error("status not cleared");

endmodule

// ===== dv/sws_cpu_model.sv
`timescale 1ns/1ns

module sws_cpu_model #(
    parameter int OSC_START = 40
) (
    input wire logic aclk,
    input wire logic stop_cmd,
    input wire logic [7:0] irq_cmd,
    input wire logic [7:0] mask_cmd,
    input wire logic crystal_oscillator_enable,
    output logic stop_exec,
    output logic [7:0] int_request,
    output logic [7:0] int_mask,
    output logic crystal_oscillator_started
);
    logic stop_q;
    int osc_cnt;

    initial
    begin
        stop_q = 1'h0;
        stop_exec = 1'h0;
        int_request = 8'h00;
        int_mask = 8'hff;
        osc_cnt = 0;
    end

    // The standby instruction is a single-cycle pulse per command.
    always @(posedge aclk)
    begin
        stop_q <= stop_cmd;
        stop_exec <= stop_cmd & ~stop_q;
        int_request <= irq_cmd;
        int_mask <= mask_cmd;
    end

    always @(posedge aclk)
    begin
        if (!crystal_oscillator_enable)
            osc_cnt <= 0;
        else if (osc_cnt < OSC_START)
            osc_cnt <= osc_cnt + 1;
    end

    assign crystal_oscillator_started = (osc_cnt == OSC_START);
endmodule

// ===== dv/sws_standby_wake_osc_stabilizer_bench.sv
`timescale 1ns/1ns

module sws_standby_wake_osc_stabilizer_bench;
    localparam int OSC_START = 40;
    localparam int TICK = 80;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] awaddr = 32'h0000_0000;
    logic awvalid = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic [31:0] araddr = 32'h0000_0000;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic stop_cmd = 1'h0;
    logic [7:0] irq_cmd = 8'h00;
    logic [7:0] mask_cmd = 8'hff;
    logic stop_exec, osc_started, cpu_run, deep, light, osc_en, lso_stop;
    logic [7:0] int_request, int_mask;
    logic [31:0] rd;
    int miscompares = 0;
    int tests_run = 0;
    int n;

    sws_standby_wake_osc_stabilizer u_sws_standby_wake_osc_stabilizer (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .stop_exec(stop_exec), .int_request(int_request), .int_mask(int_mask),
        .crystal_oscillator_started(osc_started), .cpu_run(cpu_run), .deep_standby(deep),
        .light_standby(light), .crystal_oscillator_enable(osc_en), .low_speed_osc_stop(lso_stop)
    );

    sws_cpu_model #(.OSC_START(OSC_START)) u_sws_cpu_model (
        .aclk(aclk), .stop_cmd(stop_cmd), .irq_cmd(irq_cmd), .mask_cmd(mask_cmd),
        .crystal_oscillator_enable(osc_en), .stop_exec(stop_exec), .int_request(int_request),
        .int_mask(int_mask), .crystal_oscillator_started(osc_started)
    );

    initial
    begin
        forever #25 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Checking and closing.
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register bus master.
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'h1)
                awvalid <= 1'h0;
            if (wvalid && wready === 1'h1)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready === 1'h1)
                arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        d = rdata;
        rready <= 1'h0;
    endtask

    // ------------------------------------------------------------
    // Sequencer helpers.
    // ------------------------------------------------------------
    task automatic do_stop;
        stop_cmd <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (cpu_run === 1'h1 && n < 20);
        stop_cmd <= 1'h0;
    endtask

    task automatic wait_run;
        n = 0;
        while (cpu_run !== 1'h1 && n < 25000)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    initial
    begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        give_verdict();
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        axi_rd(sws_pkg::OFS_WAIT_SEL, sws_pkg::RESP_OKAY, rd);
        check("wait_sel_reset", rd, 32'h0000_0007);
        axi_rd(sws_pkg::OFS_OPTION, sws_pkg::RESP_OKAY, rd);
        check("option_reset", rd, 32'h0000_0000);
        axi_rd(32'h0000_0040, sws_pkg::RESP_SLVERR, rd);
        check("unmapped_rdata", rd, 32'h0000_0000);
        axi_wr(32'h0000_0040, 32'h0000_0001, sws_pkg::RESP_SLVERR);
        $display("Test registers done");
        axi_wr(sws_pkg::OFS_WAIT_SEL, 32'h0000_0002, sws_pkg::RESP_OKAY);
        repeat (OSC_START + 10) @(posedge aclk);
        irq_cmd <= 8'h10;
        mask_cmd <= 8'hef;
        do_stop();
        check("cancel_deep", {31'h0, deep}, 32'h0000_0000);
        check("cancel_light", {31'h0, light}, 32'h0000_0001);
        wait_run();
        check("cancel_wait_min", n >= 31 * TICK, 32'h0000_0001);
        irq_cmd <= 8'h00;
        axi_rd(sws_pkg::OFS_STATUS, sws_pkg::RESP_OKAY, rd);
        check("status_sel2", rd, 32'h0000_00e0);
        $display("Test cancelled standby done");
        axi_wr(sws_pkg::OFS_WAIT_SEL, 32'h0000_0000, sws_pkg::RESP_OKAY);
        axi_wr(sws_pkg::OFS_OPTION, 32'h0000_0000, sws_pkg::RESP_OKAY);
        irq_cmd <= 8'h01;
        mask_cmd <= 8'hff;
        do_stop();
        check("deep_entry", {31'h0, deep}, 32'h0000_0001);
        check("lso_stop", {31'h0, lso_stop}, 32'h0000_0001);
        check("osc_disabled", {31'h0, osc_en}, 32'h0000_0000);
        axi_rd(sws_pkg::OFS_STATUS, sws_pkg::RESP_OKAY, rd);
        check("status_cleared", rd, 32'h0000_0000);
        axi_wr(sws_pkg::OFS_STATUS, 32'h0000_00ff, sws_pkg::RESP_OKAY);
        axi_rd(sws_pkg::OFS_STATE, sws_pkg::RESP_OKAY, rd);
        check("state_deep", rd, 32'h0000_0001);
        mask_cmd <= 8'hfe;
        n = 0;
        while (light !== 1'h1 && n < 10)
        begin
            @(posedge aclk);
            n++;
        end
        check("wake_light", {31'h0, light}, 32'h0000_0001);
        wait_run();
        check("wake_min", n >= OSC_START + 7 * TICK, 32'h0000_0001);
        check("wake_max", n <= OSC_START + 8 * TICK + 8, 32'h0000_0001);
        irq_cmd <= 8'h00;
        repeat (3 * TICK) @(posedge aclk);
        axi_rd(sws_pkg::OFS_STATUS, sws_pkg::RESP_OKAY, rd);
        check("status_sel0", rd, 32'h0000_0080);
        axi_rd(sws_pkg::OFS_STATE, sws_pkg::RESP_OKAY, rd);
        check("state_restarted", rd, 32'h0000_0004);
        $display("Test deep standby done");
        axi_wr(sws_pkg::OFS_OPTION, 32'h0000_0001, sws_pkg::RESP_OKAY);
        axi_wr(sws_pkg::OFS_WAIT_SEL, 32'h0000_0005, sws_pkg::RESP_OKAY);
        do_stop();
        check("lso_kept", {31'h0, lso_stop}, 32'h0000_0000);
        irq_cmd <= 8'h80;
        mask_cmd <= 8'h7f;
        wait_run();
        check("wake_again", {31'h0, cpu_run}, 32'h0000_0001);
        check("wake_sel5_min", n >= OSC_START + 255 * TICK, 32'h0000_0001);
        check("wake_sel5_max", n <= OSC_START + 256 * TICK + 12, 32'h0000_0001);
        axi_rd(sws_pkg::OFS_STATUS, sws_pkg::RESP_OKAY, rd);
        check("status_sel5", rd, 32'h0000_00fc);
        $display("Test option bit done");
        give_verdict();
    end
endmodule
